// ---- rtl/usb_lowspeed_endpoint_flags.sv ----
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module usb_lowspeed_endpoint_flags
	import usb_flags_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int COUNT_W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [DATA_W-1:0] writedata_i,
	input wire logic [DATA_W/8-1:0] byteenable_i,
	output logic [DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	// bus line events from the packet engine plus keyboard, port B0 and timer events, one-cycle pulses
	input wire logic bus_reset_det_i,
	input wire logic bus_suspend_det_i,
	input wire logic bus_resume_det_i,
	input wire logic ep2_tx_done_i,
	input wire logic keyboard_event_i,
	input wire logic port_b0_event_i,
	input wire logic timer_zero_event_i,
	// token seen from the host
	input wire logic token_valid_i,
	input wire logic [1:0] token_kind_i,
	input wire logic [1:0] token_ep_i,
	input wire logic control_read_active_i,
	output resp_t resp_code_o,
	output logic resp_valid_o,
	output logic [COUNT_W-1:0] tx_byte_count_o,
	// transfer completions
	input wire logic ep0_rx_done_i,
	input wire logic ep0_rx_toggle_i,
	input wire logic ep0_rx_error_i,
	input wire logic [COUNT_W-1:0] ep0_rx_byte_count_i,
	input wire logic in_done_i,
	input wire logic [1:0] in_done_ep_i,
	// power and configuration
	output logic suspend_o,
	output logic remote_resume_drive_o,
	output logic ep1_enable_o,
	output logic ep2_enable_o
);

	if (DATA_W < 8 || COUNT_W != 4) begin : g_check
		$error("DATA_W must be at least 8 and COUNT_W must be 4");
	end

	//////////////////////////////////////////////////////////////////////////
	// register bus: one wait cycle, then one answer cycle
	logic ack_reg;
	logic wr_en;
	logic [7:0] wdata;
	logic [7:0] rd_mux;
	logic [DATA_W-1:0] readdata_reg;

	logic [7:0] usb_flags_reg;
	logic [7:0] misc_flags_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] rx_status_reg;
	logic [7:0] ep0_tx_reg;
	logic [7:0] ep1_tx_reg;
	logic bus_suspended_reg;
	logic rx_done_dly_reg;
	resp_t resp_reg;
	logic resp_valid_reg;
	logic [COUNT_W-1:0] tx_count_reg;

	assign waitrequest_o = (read_i | write_i) & ~ack_reg;
	assign wr_en = write_i & ack_reg & byteenable_i[0];
	assign wdata = writedata_i[7:0];
	assign readdata_o = readdata_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read_i | write_i) & ~ack_reg;
		end
	end

	always_comb begin
		case (address_i)
			USB_EVENT_FLAGS_OFS: rd_mux = usb_flags_reg;
			MISC_EVENT_FLAGS_OFS: rd_mux = misc_flags_reg;
			USB_POWER_EP_CTRL_OFS: rd_mux = ctrl_reg;
			EP0_RX_STATUS_OFS: rd_mux = rx_status_reg;
			EP0_TX_CTRL_OFS: rd_mux = ep0_tx_reg;
			EP1_TX_CTRL_OFS: rd_mux = ep1_tx_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readdata_reg <= '0;
		end else if (read_i & ~ack_reg) begin
			readdata_reg <= {{(DATA_W-8){1'b0}}, rd_mux};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// event flags: set wins over a write of 0
	logic [7:0] usb_set;
	logic [7:0] misc_set;
	logic [7:0] usb_clr;
	logic [7:0] misc_clr;
	logic ep0_in_done;
	logic ep1_in_done;

	assign ep0_in_done = in_done_i & (in_done_ep_i == 2'h0);
	assign ep1_in_done = in_done_i & (in_done_ep_i == 2'h1);

	always_comb begin
		usb_set = 8'h00;
		usb_set[EP0_RX_DONE_BIT] = rx_done_dly_reg;
		usb_set[EP0_TX_DONE_BIT] = ep0_in_done;
		usb_set[EP1_TX_DONE_BIT] = ep1_in_done;
		usb_set[EP2_TX_DONE_BIT] = ep2_tx_done_i;
		usb_set[BUS_RESET_BIT] = bus_reset_det_i;
		usb_set[SUSPEND_EVT_BIT] = bus_suspend_det_i;
		misc_set = 8'h00;
		misc_set[RESUME_EVT_BIT] = bus_resume_det_i;
		misc_set[KEYBOARD_BIT] = keyboard_event_i;
		misc_set[PORT_B0_BIT] = port_b0_event_i;
		misc_set[TIMER_ZERO_BIT] = timer_zero_event_i;
	end

	assign usb_clr = (wr_en && address_i == USB_EVENT_FLAGS_OFS) ?
		~wdata : 8'h00;
	assign misc_clr = (wr_en && address_i == MISC_EVENT_FLAGS_OFS) ?
		~wdata : 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_flags_reg <= REG_RESET;
			misc_flags_reg <= REG_RESET;
		end else begin
			usb_flags_reg <= ((usb_flags_reg & ~usb_clr) | usb_set) &
				USB_FLAGS_MASK;
			misc_flags_reg <= ((misc_flags_reg & ~misc_clr) | misc_set) &
				MISC_FLAGS_MASK;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// power, endpoint configuration and receive ready
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= REG_RESET;
		end else if (wr_en && address_i == USB_POWER_EP_CTRL_OFS) begin
			ctrl_reg <= wdata & CTRL_MASK;
		end else if (rx_done_dly_reg) begin
			ctrl_reg[EP0_RX_READY_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_suspended_reg <= 1'b0;
		end else if (bus_resume_det_i | bus_reset_det_i) begin
			bus_suspended_reg <= 1'b0;
		end else if (bus_suspend_det_i) begin
			bus_suspended_reg <= 1'b1;
		end
	end

	assign suspend_o = bus_suspended_reg | ctrl_reg[FORCE_SUSPEND_BIT];
	assign remote_resume_drive_o = suspend_o &
		ctrl_reg[REMOTE_RESUME_BIT];
	assign ep1_enable_o = ctrl_reg[EP1_ENABLE_BIT];
	assign ep2_enable_o = ctrl_reg[EP2_ENABLE_BIT];

	//////////////////////////////////////////////////////////////////////////
	// ep0 receive status, captured one cycle ahead of its done flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_done_dly_reg <= 1'b0;
		end else begin
			rx_done_dly_reg <= ep0_rx_done_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_status_reg <= REG_RESET;
		end else begin
			if (ep0_rx_done_i) begin
				rx_status_reg[RX_TOGGLE_BIT] <= ep0_rx_toggle_i;
				rx_status_reg[RX_ERROR_BIT] <= ep0_rx_error_i;
				rx_status_reg[COUNT_W-1:0] <= ep0_rx_byte_count_i;
			end
			if (token_valid_i && token_ep_i == 2'h0) begin
				rx_status_reg[DIRECTION_BIT] <= token_kind_i == TOKEN_IN;
				rx_status_reg[SETUP_SEEN_BIT] <=
					token_kind_i == TOKEN_SETUP;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// transmit control: firmware write takes priority over hardware clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep0_tx_reg <= REG_RESET;
		end else if (wr_en && address_i == EP0_TX_CTRL_OFS) begin
			ep0_tx_reg <= wdata & EP0_TX_MASK;
		end else if (ep0_in_done) begin
			ep0_tx_reg[TX_READY_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep1_tx_reg <= REG_RESET;
		end else if (wr_en && address_i == EP1_TX_CTRL_OFS) begin
			ep1_tx_reg <= wdata & EP1_TX_MASK;
		end else if (ep1_in_done) begin
			ep1_tx_reg[TX_READY_BIT] <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// token answer, one cycle after the token
	resp_t resp_next;
	logic [COUNT_W-1:0] tx_count_next;

	always_comb begin
		resp_next = RESP_NAK;
		tx_count_next = '0;
		case (token_ep_i)
			2'h0: begin
				if (token_kind_i == TOKEN_SETUP) begin
					resp_next = RESP_ACCEPT;
				end else if (ep0_tx_reg[EP0_HALT_BIT]) begin
					resp_next = RESP_STALL;
				end else if (token_kind_i == TOKEN_IN) begin
					if (ep0_tx_reg[TX_READY_BIT]) begin
						resp_next = ep0_tx_reg[TX_TOGGLE_BIT] ?
							RESP_DATA1 : RESP_DATA0;
						tx_count_next = ep0_tx_reg[COUNT_W-1:0];
					end
				end else if (ctrl_reg[GUARD_BIT] & control_read_active_i) begin
					resp_next = RESP_STALL;
				end else if (ctrl_reg[EP0_RX_READY_BIT]) begin
					resp_next = RESP_ACCEPT;
				end else begin
					resp_next = RESP_NAK;
				end
			end
			2'h1: begin
				if (!ctrl_reg[EP1_ENABLE_BIT] || token_kind_i != TOKEN_IN) begin
					resp_next = RESP_NONE;
				end else if (ep1_tx_reg[TX_READY_BIT]) begin
					resp_next = ep1_tx_reg[TX_TOGGLE_BIT] ?
						RESP_DATA1 : RESP_DATA0;
				end else begin
					resp_next = RESP_NAK;
				end
			end
			2'h2: begin
				resp_next = ctrl_reg[EP2_ENABLE_BIT] ? RESP_NAK : RESP_NONE;
			end
			default: begin
				resp_next = RESP_NONE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_reg <= RESP_NONE;
			resp_valid_reg <= 1'b0;
			tx_count_reg <= '0;
		end else begin
			resp_valid_reg <= token_valid_i & ~suspend_o;
			if (token_valid_i & ~suspend_o) begin
				resp_reg <= resp_next;
				tx_count_reg <= tx_count_next;
			end
		end
	end

	assign resp_code_o = resp_reg;
	assign resp_valid_o = resp_valid_reg;
	assign tx_byte_count_o = tx_count_reg;

	//////////////////////////////////////////////////////////////////////////
	// checks
	bus_reset_set_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		bus_reset_det_i |=> usb_flags_reg[BUS_RESET_BIT])
		else $error("bus reset flag not set");
	suspend_flag_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		bus_suspend_det_i |=> usb_flags_reg[SUSPEND_EVT_BIT])
		else $error("suspend flag not set");
	flag_hold_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		misc_flags_reg[TIMER_ZERO_BIT] && !misc_clr[TIMER_ZERO_BIT]
		|=> misc_flags_reg[TIMER_ZERO_BIT])
		else $error("timer flag lost");
	force_suspend_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg[FORCE_SUSPEND_BIT] |-> suspend_o)
		else $error("forced suspend not applied");
	quiet_suspend_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		token_valid_i && suspend_o |=> !resp_valid_o)
		else $error("token answered while suspended");
	resume_drive_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		remote_resume_drive_o |-> suspend_o && ctrl_reg[REMOTE_RESUME_BIT])
		else $error("resume driven outside suspend");
	rx_order_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ep0_rx_done_i && !rx_done_dly_reg && !usb_flags_reg[EP0_RX_DONE_BIT]
		|=> !usb_flags_reg[EP0_RX_DONE_BIT]
		##1 usb_flags_reg[EP0_RX_DONE_BIT])
		else $error("rx done flag order broken");
	rx_ready_clr_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done_dly_reg && !(wr_en && address_i == USB_POWER_EP_CTRL_OFS)
		|=> !ctrl_reg[EP0_RX_READY_BIT] && usb_flags_reg[EP0_RX_DONE_BIT])
		else $error("rx ready not cleared with flag");
	rx_flags_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ep0_rx_done_i
		|=> rx_status_reg[RX_TOGGLE_BIT] == $past(ep0_rx_toggle_i) &&
		rx_status_reg[RX_ERROR_BIT] == $past(ep0_rx_error_i))
		else $error("rx toggle or error not captured");
	token_dir_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		token_valid_i && token_ep_i == 2'h0 |=>
		rx_status_reg[DIRECTION_BIT] == ($past(token_kind_i) == TOKEN_IN) &&
		rx_status_reg[SETUP_SEEN_BIT] ==
		($past(token_kind_i) == TOKEN_SETUP))
		else $error("ep0 direction or setup indicator wrong");
	rx_count_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ep0_rx_done_i |=> rx_status_reg[COUNT_W-1:0] ==
		$past(ep0_rx_byte_count_i))
		else $error("rx byte count not captured");
	tx_ready_clr_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ep0_in_done && !(wr_en && address_i == EP0_TX_CTRL_OFS)
		|=> !ep0_tx_reg[TX_READY_BIT] && usb_flags_reg[EP0_TX_DONE_BIT])
		else $error("ep0 tx ready not cleared");
	ep0_stall_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		token_valid_i && !suspend_o && token_ep_i == 2'h0 &&
		token_kind_i != TOKEN_SETUP && ep0_tx_reg[EP0_HALT_BIT]
		|=> resp_valid_o && resp_code_o == RESP_STALL)
		else $error("halted ep0 not stalled");
	ep0_data_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		token_valid_i && !suspend_o && token_ep_i == 2'h0 &&
		token_kind_i == TOKEN_IN && !ep0_tx_reg[EP0_HALT_BIT] &&
		ep0_tx_reg[TX_READY_BIT]
		|=> tx_byte_count_o == $past(ep0_tx_reg[COUNT_W-1:0]) &&
		resp_code_o ==
		($past(ep0_tx_reg[TX_TOGGLE_BIT]) ? RESP_DATA1 : RESP_DATA0))
		else $error("wrong ep0 data answer");
	ep1_ready_clr_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		ep1_in_done && !(wr_en && address_i == EP1_TX_CTRL_OFS)
		|=> !ep1_tx_reg[TX_READY_BIT] && usb_flags_reg[EP1_TX_DONE_BIT])
		else $error("ep1 tx ready not cleared");
	nak_idle_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		token_valid_i && !suspend_o && token_ep_i == 2'h1 &&
		token_kind_i == TOKEN_IN && ep1_enable_o && !ep1_tx_reg[TX_READY_BIT]
		|=> resp_code_o == RESP_NAK)
		else $error("idle ep1 not answered with NAK");
	bus_answer_a:
		assert property (@(posedge clk_i) disable iff (rst_i)
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("bus answer late");

endmodule : usb_lowspeed_endpoint_flags

// ---- rtl/usb_flags_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - bus reset detection sets the bus reset flag; reset 0, write 0 clears
// - bus suspend sets the suspend event flag; reset 0, write 0 clears
// - resume signalling sets the resume event flag; reset 0, write 0 clears
// - endpoint 2 IN completion sets its done flag; reset 0, write 0 clears
// - keyboard event flag in the misc flag register; reset 0, write 0 clears
// - port B pin 0 event flag; reset 0, write 0 clears
// - timer zero event flag beside port and keyboard flags; write 0 clears
// - forced suspend bit puts the USB interface into suspend; resets 0
// - remote resume bit drives resume signalling while suspended; resets 0
// - separate enable bits for endpoint 1 and endpoint 2, both reset 0
// - guard bit set: invalid OUT during control read answered with STALL
// - firmware arms ep0 receive ready; hardware clears it with rx done flag
// - read-only ep0 toggle of last received packet, 1 DATA1, 0 DATA0
// - read-only flag telling ep0 received data had an error
// - read-only ep0 direction, 1 IN, 0 OUT or SETUP
// - read-only indicator that current ep0 transaction began with SETUP
// - read-only four-bit count of bytes in last ep0 packet
// - firmware arms ep0 transmit ready; hardware clears it with tx done flag
// - ep0 IN data sent as DATA1 or DATA0 per writable toggle, reset 0
// - ep0 halt bit set: OUT and IN on ep0 answered with STALL
// - firmware writes ep0 byte count; that many bytes sent in next IN
// - ep1 transmit ready cleared by hardware with ep1 done; own toggle bit
// - ep0 reception completion sets ep0 rx done flag; write 0 clears
// - ep0 IN completion sets ep0 tx done flag; write 0 clears
// - ep1 IN completion sets ep1 tx done flag; write 0 clears
//////////////////////////////////////////////////////////////////////////////
package usb_flags_pkg;
	// register byte addresses
	localparam logic [4:0] USB_EVENT_FLAGS_OFS = 5'h00;
	localparam logic [4:0] MISC_EVENT_FLAGS_OFS = 5'h04;
	localparam logic [4:0] USB_POWER_EP_CTRL_OFS = 5'h08;
	localparam logic [4:0] EP0_RX_STATUS_OFS = 5'h0C;
	localparam logic [4:0] EP0_TX_CTRL_OFS = 5'h10;
	localparam logic [4:0] EP1_TX_CTRL_OFS = 5'h14;
	// usb_event_flags fields
	localparam int EP0_RX_DONE_BIT = 7;
	localparam int EP0_TX_DONE_BIT = 6;
	localparam int EP1_TX_DONE_BIT = 5;
	localparam int EP2_TX_DONE_BIT = 4;
	localparam int BUS_RESET_BIT = 3;
	localparam int SUSPEND_EVT_BIT = 2;
	localparam logic [7:0] USB_FLAGS_MASK = 8'hFC;
	// misc_event_flags fields
	localparam int RESUME_EVT_BIT = 3;
	localparam int KEYBOARD_BIT = 2;
	localparam int PORT_B0_BIT = 1;
	localparam int TIMER_ZERO_BIT = 0;
	localparam logic [7:0] MISC_FLAGS_MASK = 8'h0F;
	// usb_power_endpoint_control fields
	localparam int FORCE_SUSPEND_BIT = 7;
	localparam int REMOTE_RESUME_BIT = 6;
	localparam int EP1_ENABLE_BIT = 5;
	localparam int EP2_ENABLE_BIT = 4;
	localparam int GUARD_BIT = 3;
	localparam int EP0_RX_READY_BIT = 0;
	localparam logic [7:0] CTRL_MASK = 8'hF9;
	// ep0_receive_status fields
	localparam int RX_TOGGLE_BIT = 7;
	localparam int RX_ERROR_BIT = 6;
	localparam int DIRECTION_BIT = 5;
	localparam int SETUP_SEEN_BIT = 4;
	// transmit control fields
	localparam int TX_READY_BIT = 7;
	localparam int TX_TOGGLE_BIT = 6;
	localparam int EP0_HALT_BIT = 5;
	localparam logic [7:0] EP0_TX_MASK = 8'hEF;
	localparam logic [7:0] EP1_TX_MASK = 8'hC0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// token kinds from the packet engine
	localparam logic [1:0] TOKEN_OUT = 2'h0;
	localparam logic [1:0] TOKEN_IN = 2'h1;
	localparam logic [1:0] TOKEN_SETUP = 2'h2;
	// answers to a token
	typedef enum logic [2:0] {
		RESP_NONE = 3'h0,
		RESP_NAK = 3'h1,
		RESP_STALL = 3'h2,
		RESP_ACCEPT = 3'h3,
		RESP_DATA0 = 3'h4,
		RESP_DATA1 = 3'h5
	} resp_t;
endpackage : usb_flags_pkg

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
module host_model
	import usb_flags_pkg::*;
(
	input wire logic clk_i,
	output logic token_valid_o,
	output logic [1:0] token_kind_o,
	output logic [1:0] token_ep_o,
	output logic control_read_active_o,
	output logic ep0_rx_done_o,
	output logic ep0_rx_toggle_o,
	output logic ep0_rx_error_o,
	output logic [3:0] ep0_rx_byte_count_o,
	output logic in_done_o,
	output logic [1:0] in_done_ep_o,
	input wire resp_t resp_code_i,
	input wire logic resp_valid_i,
	input wire logic [3:0] tx_byte_count_i
);
	initial begin
		token_valid_o = 1'b0;
		token_kind_o = 2'h3;
		token_ep_o = 2'h3;
		control_read_active_o = 1'b0;
		ep0_rx_done_o = 1'b0;
		ep0_rx_toggle_o = 1'b0;
		ep0_rx_error_o = 1'b0;
		ep0_rx_byte_count_o = 4'h0;
		in_done_o = 1'b0;
		in_done_ep_o = 2'h3;
	end
	//////////////////////////////////////////////////////////////////////////
	// unqualified lines except control_read_active_o carry the inverse so stale values never look valid
	task automatic send_token(input logic [1:0] kind, input logic [1:0] ep,
		input logic cra, output logic v, output logic [2:0] code,
		output logic [3:0] cnt);
		@(posedge clk_i);
		token_valid_o <= 1'b1;
		token_kind_o <= kind;
		token_ep_o <= ep;
		control_read_active_o <= cra;
		@(posedge clk_i);
		token_valid_o <= 1'b0;
		token_kind_o <= ~kind;
		token_ep_o <= ~ep;
		@(negedge clk_i);
		v = resp_valid_i;
		code = resp_code_i;
		cnt = tx_byte_count_i;
	endtask : send_token
	task automatic rx_done(input logic tgl, input logic err,
		input logic [3:0] cnt);
		@(posedge clk_i);
		ep0_rx_done_o <= 1'b1;
		ep0_rx_toggle_o <= tgl;
		ep0_rx_error_o <= err;
		ep0_rx_byte_count_o <= cnt;
		@(posedge clk_i);
		ep0_rx_done_o <= 1'b0;
		ep0_rx_toggle_o <= ~tgl;
		ep0_rx_error_o <= ~err;
		ep0_rx_byte_count_o <= ~cnt;
	endtask : rx_done
	task automatic ack_in(input logic [1:0] ep);
		@(posedge clk_i);
		in_done_o <= 1'b1;
		in_done_ep_o <= ep;
		@(posedge clk_i);
		in_done_o <= 1'b0;
		in_done_ep_o <= ~ep;
	endtask : ack_in
endmodule : host_model

// ---- bench/usb_lowspeed_endpoint_flags_bench.sv ----
`timescale 1ns/1ps
module usb_lowspeed_endpoint_flags_bench
	import usb_flags_pkg::*;
;
	logic clk_i, rst_i, read_i, write_i, tv, cra, rxd, rxt, rxe, ind;
	logic [4:0] address_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic [3:0] byteenable_i, rxc, txc;
	logic [1:0] tk, te, inep;
	logic [6:0] evt;
	logic waitrequest_o, resp_valid_o, susp, rres, en1, en2;
	resp_t resp_code_o;
	int num_errors = 0;
	int checks = 0;
	usb_lowspeed_endpoint_flags usb_lowspeed_endpoint_flags_i (.clk_i(clk_i),
		.rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .bus_reset_det_i(evt[0]),
		.bus_suspend_det_i(evt[1]), .bus_resume_det_i(evt[2]),
		.ep2_tx_done_i(evt[3]), .keyboard_event_i(evt[4]),
		.port_b0_event_i(evt[5]), .timer_zero_event_i(evt[6]),
		.token_valid_i(tv), .token_kind_i(tk), .token_ep_i(te),
		.control_read_active_i(cra), .resp_code_o(resp_code_o),
		.resp_valid_o(resp_valid_o), .tx_byte_count_o(txc),
		.ep0_rx_done_i(rxd), .ep0_rx_toggle_i(rxt), .ep0_rx_error_i(rxe),
		.ep0_rx_byte_count_i(rxc), .in_done_i(ind), .in_done_ep_i(inep),
		.suspend_o(susp), .remote_resume_drive_o(rres),
		.ep1_enable_o(en1), .ep2_enable_o(en2));
	host_model host_model_i (.clk_i(clk_i), .token_valid_o(tv),
		.token_kind_o(tk), .token_ep_o(te), .control_read_active_o(cra),
		.ep0_rx_done_o(rxd), .ep0_rx_toggle_o(rxt), .ep0_rx_error_o(rxe),
		.ep0_rx_byte_count_o(rxc), .in_done_o(ind), .in_done_ep_o(inep),
		.resp_code_i(resp_code_o), .resp_valid_i(resp_valid_o),
		.tx_byte_count_i(txc));
	//////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// one avalon transfer; waits for waitrequest low, then releases
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		address_i <= a;
		read_i <= ~w;
		write_i <= w;
		writedata_i <= {24'h000000, d};
		byteenable_i <= be;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 100);
		if (n >= 100)
			check("waitrequest", waitrequest_o, 32'h0);
		r = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		// let the write settle before any output is looked at
		@(negedge clk_i);
	endtask : xfer
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be = 4'hF);
		xfer(1'b1, a, d, be, q);
	endtask : wr
	task automatic rc(input string nm, input logic [4:0] a,
		input logic [7:0] exp);
		xfer(1'b0, a, 8'h00, 4'hF, q);
		check(nm, q, {24'h000000, exp});
	endtask : rc
	task automatic pulse(input int i);
		@(posedge clk_i);
		evt[i] <= 1'b1;
		@(posedge clk_i);
		evt[i] <= 1'b0;
		@(negedge clk_i);
	endtask : pulse
	task automatic tok(input logic [1:0] kind, input logic [1:0] ep,
		input logic c, input logic ev, input resp_t ec, input logic [3:0] en);
		logic v;
		logic [2:0] code;
		logic [3:0] cnt;
		host_model_i.send_token(kind, ep, c, v, code, cnt);
		check("resp_valid", v, ev);
		if (ev) begin
			check("resp_code", code, ec);
			check("tx_count", cnt, en);
		end
	endtask : tok
	//////////////////////////////////////////////////////////////////////////
	logic [4:0] ofs [7] = '{5'h00, 5'h00, 5'h04, 5'h00, 5'h04, 5'h04, 5'h04};
	int bitn [7] = '{3, 2, 3, 4, 2, 1, 0};
	logic [4:0] regs [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		#(50 * 20000);
		num_errors++;
		results();
	end
	initial begin
		rst_i = 1'b1;
		{read_i, write_i, address_i, writedata_i, byteenable_i} = '0;
		evt = 7'h00;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (regs[i])
			rc("reset value", regs[i], REG_RESET);
		foreach (ofs[i]) begin
			pulse(i);
			if (i == 1 || i == 2)
				check("suspend_o", susp, i == 1);
			rc("event flag", ofs[i], 8'h01 << bitn[i]);
			wr(ofs[i], 8'hFF);
			rc("flag kept", ofs[i], 8'h01 << bitn[i]);
			wr(ofs[i], 8'h00);
			wr(ofs[i], 8'hFF);
			rc("flag cleared", ofs[i], 8'h00);
		end
		wr(USB_POWER_EP_CTRL_OFS, 8'hFF);
		rc("control", USB_POWER_EP_CTRL_OFS, CTRL_MASK);
		check("config", {susp, rres, en1, en2}, 4'hF);
		wr(USB_POWER_EP_CTRL_OFS, 8'h00, 4'h0);
		rc("control be", USB_POWER_EP_CTRL_OFS, CTRL_MASK);
		tok(TOKEN_IN, 2'h0, 1'b0, 1'b0, RESP_NONE, 4'h0);
		wr(USB_POWER_EP_CTRL_OFS, 8'h40);
		check("awake", {susp, rres, en1, en2}, 4'h0);
		wr(USB_POWER_EP_CTRL_OFS, 8'h09);
		tok(TOKEN_OUT, 2'h0, 1'b1, 1'b1, RESP_STALL, 4'h0);
		tok(TOKEN_OUT, 2'h0, 1'b0, 1'b1, RESP_ACCEPT, 4'h0);
		tok(TOKEN_SETUP, 2'h0, 1'b0, 1'b1, RESP_ACCEPT, 4'h0);
		host_model_i.rx_done(1'b1, 1'b1, 4'hA);
		rc("rx status", EP0_RX_STATUS_OFS, 8'hDA);
		rc("rx flag", USB_EVENT_FLAGS_OFS, 8'h80);
		rc("rx ready", USB_POWER_EP_CTRL_OFS, 8'h08);
		wr(USB_EVENT_FLAGS_OFS, 8'h00);
		tok(TOKEN_OUT, 2'h0, 1'b0, 1'b1, RESP_NAK, 4'h0);
		wr(EP0_TX_CTRL_OFS, 8'hFF);
		rc("ep0 tx", EP0_TX_CTRL_OFS, EP0_TX_MASK);
		tok(TOKEN_IN, 2'h0, 1'b0, 1'b1, RESP_STALL, 4'h0);
		tok(TOKEN_OUT, 2'h0, 1'b0, 1'b1, RESP_STALL, 4'h0);
		wr(EP0_TX_CTRL_OFS, 8'hC5);
		tok(TOKEN_IN, 2'h0, 1'b0, 1'b1, RESP_DATA1, 4'h5);
		host_model_i.ack_in(2'h0);
		rc("tx0 flag", USB_EVENT_FLAGS_OFS, 8'h40);
		rc("tx0 ready", EP0_TX_CTRL_OFS, 8'h45);
		wr(USB_EVENT_FLAGS_OFS, 8'h00);
		wr(EP0_TX_CTRL_OFS, 8'h8F);
		tok(TOKEN_IN, 2'h0, 1'b0, 1'b1, RESP_DATA0, 4'hF);
		wr(EP0_TX_CTRL_OFS, 8'h00);
		tok(TOKEN_IN, 2'h0, 1'b0, 1'b1, RESP_NAK, 4'h0);
		xfer(1'b0, EP0_RX_STATUS_OFS, 8'h00, 4'hF, q);
		check("direction", q & 32'h30, 32'h20);
		tok(TOKEN_IN, 2'h1, 1'b0, 1'b1, RESP_NONE, 4'h0);
		wr(USB_POWER_EP_CTRL_OFS, 8'h30);
		tok(TOKEN_IN, 2'h2, 1'b0, 1'b1, RESP_NAK, 4'h0);
		tok(TOKEN_IN, 2'h1, 1'b0, 1'b1, RESP_NAK, 4'h0);
		wr(EP1_TX_CTRL_OFS, 8'hFF);
		rc("ep1 tx", EP1_TX_CTRL_OFS, EP1_TX_MASK);
		tok(TOKEN_IN, 2'h1, 1'b0, 1'b1, RESP_DATA1, 4'h0);
		host_model_i.ack_in(2'h1);
		rc("tx1 flag", USB_EVENT_FLAGS_OFS, 8'h20);
		rc("tx1 ready", EP1_TX_CTRL_OFS, 8'h40);
		host_model_i.rx_done(1'b0, 1'b0, 4'h3);
		rc("rx status zero", EP0_RX_STATUS_OFS, 8'h23);
		results();
	end
endmodule : usb_lowspeed_endpoint_flags_bench
